// >>> rtl/ehi_host_if.v
// Purpose: 32-bit expansion bus slave interface, I/O and burst DMA paths
// Assumes: every bus pin is asynchronous to CLK and passes two flops
// Notes: strobes narrower than one CLK period may be missed
`timescale 1ns/100ps
`default_nettype none
`include "ehi_defs.vh"

// Overview of operation
// RQ1: write data taken at write strobe end
// RQ2: host keeps strobes idle during bursts
// RQ3: host drives address strobe from start
// RQ4: byte enables captured at address strobe rise
// RQ5: interrupt output active high, edge use
// RQ6: dword, low half, high half decoded
// RQ7: single byte lanes decoded
// RQ8: unselected lanes float on reads, ignored writes
// RQ9: upper byte enables replace address bit one
// RQ10: host issues only listed patterns
// RQ11: local decode low on match, enable low
// RQ12: external no-wait request ends at start
// RQ13: compressed cycles accepted
// RQ14: burst clock paces DMA transfers
// RQ15: acknowledge selects direct data path
// RQ16: direction high write, low read
// RQ17: cycle indication marks DMA writes
// RQ18: ready return transfers or postpones
// RQ19: address captured at strobe trailing edge
// RQ20: enable transparent while strobe low
// RQ21: one aligned word per burst clock
module ehi_host_if #(
  parameter [11:0] DECODE_BASE = `EHI_DECODE_BASE
) (
  input wire CLK,
  input wire RESET_N,
  input wire WRITE_STROBE_N,
  input wire READ_STROBE_N,
  input wire ADDR_LATCH_STROBE_N,
  input wire [3:0] BYTE_LANE_EN_N,
  input wire AEN,
  input wire [13:0] ADDR,
  input wire [31:0] DATA_IN,
  output reg [31:0] DATA_OUT,
  output reg [3:0] DATA_OE_N,
  output reg LOCAL_DECODE_N,
  output reg IRQ_OUT,
  input wire IRQ_REQ,
  input wire BURST_BUS_CLK,
  input wire DIRECT_PATH_SELECT_N,
  input wire TRANSFER_DIRECTION,
  input wire DMA_CYCLE_IND_N,
  input wire READY_RETURN_N,
  output reg [13:0] CUR_ADDR,
  output reg [3:0] CUR_LANES,
  output reg BAD_LANES,
  input wire [31:0] RD_DATA,
  input wire [31:0] DMA_RD_DATA,
  input wire DMA_RD_VALID,
  output wire DMA_RD_READY,
  output wire WR_VALID,
  input wire WR_READY,
  output wire [31:0] WR_DATA,
  output wire [13:0] WR_ADDR,
  output wire [3:0] WR_LANES,
  output wire WR_DMA
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_BURST = 3'b100;
  localparam BUF_W = 51;

  reg [`EHI_SYNC_W-1:0] sync1;
  reg [`EHI_SYNC_W-1:0] sync2;
  reg wr_strobe_d;
  reg as_d;
  reg bclk_d;
  reg aen_latched;
  reg [3:0] lanes_latched;
  reg bad_latched;
  reg [2:0] state;
  reg [2:0] next_state;
  reg push;
  reg [BUF_W-1:0] push_data;
  reg [31:0] next_data_out;
  reg [3:0] next_oe_n;
  reg dma_take;

  wire s_wr_n;
  wire s_rd_n;
  wire s_as_n;
  wire [3:0] s_be_n;
  wire s_aen;
  wire [13:0] s_addr;
  wire [31:0] s_data;
  wire s_bclk;
  wire s_dps_n;
  wire s_dir;
  wire s_cyc_n;
  wire s_rdy_n;
  wire as_rise;
  wire wr_rise;
  wire bclk_rise;
  wire aen_eff;
  wire buf_ready;
  wire burst_edge;
  wire dma_write;
  wire [BUF_W-1:0] buf_out;

  // lane mask for a byte enable pattern, bit 4 flags a pattern not served
  function [4:0] lane_decode;
    input [3:0] be_n;
    begin
      case (be_n)
        `EHI_BE_DWORD: lane_decode = {1'b0, `EHI_LANES_ALL}; // RQ6
        `EHI_BE_LOW_HALF: lane_decode = {1'b0, 4'h3}; // RQ6
        `EHI_BE_HIGH_HALF: lane_decode = {1'b0, 4'hc}; // RQ9
        `EHI_BE_BYTE0: lane_decode = {1'b0, 4'h1}; // RQ7
        `EHI_BE_BYTE1: lane_decode = {1'b0, 4'h2}; // RQ7
        `EHI_BE_BYTE2: lane_decode = {1'b0, 4'h4}; // RQ7
        `EHI_BE_BYTE3: lane_decode = {1'b0, 4'h8}; // RQ7
        default: lane_decode = {1'b1, `EHI_LANES_NONE}; // RQ10
      endcase
    end
  endfunction

  // merge new lanes into a word, leaving unselected lanes unchanged
  function [31:0] lane_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] lanes;
    integer i;
    begin
      lane_merge = old_word;
      for (i = 0; i < 4; i = i + 1)
        if (lanes[i])
          lane_merge[8*i +: 8] = new_word[8*i +: 8];
    end
  endfunction

  // every bus pin passes two flops before any logic reads it
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync1 <= `EHI_SYNC_RST;
      sync2 <= `EHI_SYNC_RST;
    end
    else
    begin
      sync1 <= {WRITE_STROBE_N, READ_STROBE_N, ADDR_LATCH_STROBE_N,
        BYTE_LANE_EN_N, AEN, ADDR, DATA_IN, BURST_BUS_CLK,
        DIRECT_PATH_SELECT_N, TRANSFER_DIRECTION, DMA_CYCLE_IND_N,
        READY_RETURN_N, IRQ_REQ};
      sync2 <= sync1;
    end
  end

  assign s_wr_n = sync2[59];
  assign s_rd_n = sync2[58];
  assign s_as_n = sync2[57];
  assign s_be_n = sync2[56:53];
  assign s_aen = sync2[52];
  assign s_addr = sync2[51:38];
  assign s_data = sync2[37:6];
  assign s_bclk = sync2[5];
  assign s_dps_n = sync2[4];
  assign s_dir = sync2[3];
  assign s_cyc_n = sync2[2];
  assign s_rdy_n = sync2[1];

  assign as_rise = s_as_n && !as_d;
  assign wr_rise = s_wr_n && !wr_strobe_d;
  assign bclk_rise = s_bclk && !bclk_d; // RQ14
  // at the strobe rise the latch is not yet loaded, so pass the pin on
  assign aen_eff = (s_as_n && as_d) ? aen_latched : s_aen; // RQ20
  assign burst_edge = (state == ST_BURST) && bclk_rise && !s_rdy_n; // RQ18
  assign dma_write = s_dir && !s_cyc_n; // RQ16 RQ17

  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      wr_strobe_d <= 1'b1;
      as_d <= 1'b1;
      bclk_d <= 1'b0;
      aen_latched <= 1'b1;
      lanes_latched <= `EHI_LANES_NONE;
      bad_latched <= 1'b0;
      CUR_ADDR <= 14'h0000;
      CUR_LANES <= `EHI_LANES_NONE;
      BAD_LANES <= 1'b0;
      LOCAL_DECODE_N <= `EHI_OUT_RST_N;
      IRQ_OUT <= 1'b0;
      state <= ST_IDLE;
      DATA_OUT <= 32'h00000000;
      DATA_OE_N <= `EHI_LANES_ALL;
    end
    else
    begin
      wr_strobe_d <= s_wr_n;
      as_d <= s_as_n;
      bclk_d <= s_bclk;
      if (as_rise)
      begin
        aen_latched <= s_aen; // RQ20
        CUR_ADDR <= s_addr; // RQ19
        {bad_latched, lanes_latched} <= lane_decode(s_be_n); // RQ4
        {BAD_LANES, CUR_LANES} <= lane_decode(s_be_n); // RQ4
      end
      // push-pull output, high when not selected
      LOCAL_DECODE_N <= !((s_addr[13:2] == DECODE_BASE) && !aen_eff); // RQ11
      IRQ_OUT <= sync2[0] ? 1'b1 : 1'b0; // RQ5
      state <= next_state;
      DATA_OUT <= next_data_out;
      DATA_OE_N <= next_oe_n;
    end
  end

  // interrupt level passes straight out as an active-high level
  always @*
  begin
    next_state = state;
    next_data_out = DATA_OUT;
    next_oe_n = `EHI_LANES_ALL;
    push = 1'b0;
    push_data = {BUF_W{1'b0}};
    dma_take = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (!s_dps_n) // RQ15
          next_state = ST_BURST;
        else if (!s_rd_n && !bad_latched && !aen_latched)
        begin
          next_state = ST_READ;
          next_data_out = lane_merge(32'h00000000, RD_DATA, lanes_latched);
          next_oe_n = ~lanes_latched; // RQ8
        end
        else if (wr_rise && !bad_latched && !aen_latched && buf_ready)
        begin
          // data sampled at the trailing edge, same delay as the strobe
          push = 1'b1; // RQ1 RQ13
          push_data = {1'b0, lanes_latched, CUR_ADDR,
            lane_merge(32'h00000000, s_data, lanes_latched)}; // RQ8
        end
      end
      ST_READ:
      begin
        next_oe_n = ~lanes_latched; // RQ8
        if (s_rd_n)
        begin
          next_state = ST_IDLE;
          next_oe_n = `EHI_LANES_ALL;
        end
      end
      ST_BURST:
      begin
        // strobes ignored here; the host keeps them idle
        if (s_dps_n)
          next_state = ST_IDLE; // RQ2
        else if (dma_write)
        begin
          if (burst_edge && buf_ready)
          begin
            push = 1'b1; // RQ21
            push_data = {1'b1, `EHI_LANES_ALL, 14'h0000, s_data};
          end
        end
        else
        begin
          next_oe_n = 4'h0; // RQ16
          if (burst_edge && DMA_RD_VALID)
          begin
            dma_take = 1'b1; // RQ21
            next_data_out = DMA_RD_DATA;
          end
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // a full buffer does not postpone the transfer; the word at that edge is dropped
  assign DMA_RD_READY = dma_take;

  ehi_buffer #(
    .WIDTH(BUF_W),
    .DEPTH(2)
  ) u_buffer (
    .clk(CLK),
    .reset_n(RESET_N),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(push_data),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(buf_out)
  );

  assign WR_DMA = buf_out[50];
  assign WR_LANES = buf_out[49:46];
  assign WR_ADDR = buf_out[45:32];
  assign WR_DATA = buf_out[31:0];
endmodule
`default_nettype wire

// >>> rtl/ehi_defs.vh
// Purpose: shared constants of the slave host interface
// Assumes: included by bare name from the host interface file only
// Notes: byte lane patterns are written lane 3 down to lane 0
`ifndef EHI_DEFS_VH
`define EHI_DEFS_VH

// byte lane enable patterns, bit n is lane n, active low
`define EHI_BE_DWORD 4'h0
`define EHI_BE_LOW_HALF 4'hc
`define EHI_BE_HIGH_HALF 4'h3
`define EHI_BE_BYTE0 4'he
`define EHI_BE_BYTE1 4'hd
`define EHI_BE_BYTE2 4'hb
`define EHI_BE_BYTE3 4'h7

// lane select masks, active high
`define EHI_LANES_NONE 4'h0
`define EHI_LANES_ALL 4'hf

// widths
`define EHI_DATA_W 32
`define EHI_ADDR_HI 15
`define EHI_ADDR_LO 2
`define EHI_DEC_LO 4
`define EHI_SYNC_W 60

// decode window, address bits 15 down to 4; arbitrary default
`define EHI_DECODE_BASE 12'h030

// synchroniser reset holds every pin at its idle level,
// so no false strobe edge follows reset
`define EHI_SYNC_RST 60'hff0000000000016
`define EHI_OUT_RST_N 1'b1

`endif

// >>> rtl/ehi_buffer.v
// Purpose: two-entry word buffer with valid and ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes: read data come from registers; full and empty are exact
`timescale 1ns/100ps
`default_nettype none
module ehi_buffer #(
  parameter WIDTH = 51,
  parameter DEPTH = 2
) (
  input wire clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [1:0] count;
  reg wr_ptr;
  reg rd_ptr;
  wire push;
  wire pop;

  assign in_ready = ({30'h0, count} != DEPTH);
  assign out_valid = (count != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // out_data tracks the head entry, read combinationally from mem
  always @*
  begin
    out_data = mem[rd_ptr];
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/ehi_monitor.sv
// Purpose: port checker for the slave interface
// Assumes: bound to ehi_host_if, pins pass two sync flops
// Notes: windows allow for the sync delay
`timescale 1ns/100ps
`default_nettype none
module ehi_monitor #(
  parameter [11:0] DECODE_BASE = 12'h030
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic ADDR_LATCH_STROBE_N,
  input wire logic AEN,
  input wire logic [13:0] ADDR,
  input wire logic [3:0] DATA_OE_N,
  input wire logic LOCAL_DECODE_N,
  input wire logic IRQ_OUT,
  input wire logic IRQ_REQ,
  input wire logic DIRECT_PATH_SELECT_N,
  input wire logic READY_RETURN_N,
  input wire logic [3:0] CUR_LANES,
  input wire logic DMA_RD_READY,
  input wire logic WR_VALID,
  input wire logic WR_READY,
  input wire logic [31:0] WR_DATA,
  input wire logic [13:0] WR_ADDR,
  input wire logic [3:0] WR_LANES,
  input wire logic WR_DMA
);
  wire [31:0] kept = {{8{WR_LANES[3]}}, {8{WR_LANES[2]}},
    {8{WR_LANES[1]}}, {8{WR_LANES[0]}}};
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence hit_s;
    !AEN && !ADDR_LATCH_STROBE_N && ADDR[13:2] == DECODE_BASE;
  endsequence
  sequence miss_s;
    ADDR[13:2] != DECODE_BASE;
  endsequence
  dec_hit_a: assert property (hit_s [*4] |-> !LOCAL_DECODE_N)
    else $error("decode missed");
  dec_miss_a: assert property (miss_s [*4] |-> LOCAL_DECODE_N)
    else $error("decode false hit");
  oe_lanes_a: assert property (DATA_OE_N != 4'hf && DIRECT_PATH_SELECT_N
    && $past(DIRECT_PATH_SELECT_N, 4) |-> DATA_OE_N == ~CUR_LANES)
    else $error("read lanes wrong");
  wr_mask_a: assert property (WR_VALID |-> WR_LANES inside
    {4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8})
    else $error("illegal lane mask");
  wr_zero_a: assert property (WR_VALID |-> (WR_DATA & ~kept) == 0)
    else $error("unselected lane data");
  dma_word_a: assert property (WR_VALID && WR_DMA |->
    WR_LANES == 4'hf && WR_ADDR == 14'h0)
    else $error("burst word not whole");
  wr_hold_a: assert property (WR_VALID && !WR_READY |=>
    WR_VALID && $stable(WR_DATA))
    else $error("stalled word lost");
  irq_rise_a: assert property ($rose(IRQ_REQ) |-> ##[1:4] IRQ_OUT)
    else $error("irq late");
  irq_low_a: assert property (!IRQ_REQ [*5] |-> !IRQ_OUT)
    else $error("irq stuck");
  rd_wait_a: assert property (READY_RETURN_N [*5] |-> !DMA_RD_READY)
    else $error("transfer not postponed");
endmodule
bind ehi_host_if ehi_monitor #(.DECODE_BASE(DECODE_BASE)) u_mon (.CLK,
  .RESET_N, .ADDR_LATCH_STROBE_N, .AEN, .ADDR, .DATA_OE_N, .LOCAL_DECODE_N,
  .IRQ_OUT, .IRQ_REQ, .DIRECT_PATH_SELECT_N, .READY_RETURN_N, .CUR_LANES,
  .DMA_RD_READY, .WR_VALID, .WR_READY, .WR_DATA, .WR_ADDR, .WR_LANES,
  .WR_DMA);
`default_nettype wire

// >>> tb/ehi_bus_model.sv
// Purpose: bus side burst clock and ready source
// Assumes: run high for the length of a burst
// Notes: clock stands still between bursts
`timescale 1ns/100ps
`default_nettype none
module ehi_bus_model (
  input wire logic run,
  input wire logic slow,
  output logic bclk,
  output logic rdy_n
);
  always
  begin
    bclk = 1'b0;
    rdy_n = 1'b1;
    wait (run);
    while (run)
    begin
      rdy_n = slow;
      #400 bclk = 1'b1;
      #400 bclk = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/ehi_host_if_tb.sv
// Purpose: self-checking bench of the slave interface
// Assumes: 10 MHz clock, 800 ns burst clock
// Notes: inputs move on the falling edge
`timescale 1ns/100ps
`default_nettype none
module ehi_host_if_tb;
  logic clk = 1'b0, rst_n = 1'b0, wr_n = 1'b1, rd_n = 1'b1, as_n = 1'b1;
  logic aen = 1'b1, irq = 1'b0, dsel_n = 1'b1, dir = 1'b0, cyc_n = 1'b1;
  logic rdv = 1'b0, wrr = 1'b1, run = 1'b0, slow = 1'b0;
  logic [3:0] be_n = 4'hf;
  logic [13:0] addr = 14'h0;
  logic [31:0] din = 32'h0, rdd = 32'h0, drd = 32'h0;
  wire bclk, rdy_n, ldec_n, irq_o, rdr, wv, wdma, bad;
  wire [3:0] oe_n, cl, wl;
  wire [13:0] wa, ca;
  wire [31:0] dout, wd;
  int num_errors = 0, comparisons = 0, cyc = 0;
  always #50 clk = ~clk;
  ehi_bus_model u_bus (.run(run), .slow(slow), .bclk(bclk), .rdy_n(rdy_n));
  ehi_host_if u_dut (.CLK(clk), .RESET_N(rst_n), .WRITE_STROBE_N(wr_n),
    .READ_STROBE_N(rd_n), .ADDR_LATCH_STROBE_N(as_n), .BYTE_LANE_EN_N(be_n),
    .AEN(aen), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n),
    .LOCAL_DECODE_N(ldec_n), .IRQ_OUT(irq_o), .IRQ_REQ(irq),
    .BURST_BUS_CLK(bclk), .DIRECT_PATH_SELECT_N(dsel_n),
    .TRANSFER_DIRECTION(dir), .DMA_CYCLE_IND_N(cyc_n),
    .READY_RETURN_N(rdy_n), .CUR_ADDR(ca), .CUR_LANES(cl), .BAD_LANES(bad),
    .RD_DATA(rdd), .DMA_RD_DATA(drd), .DMA_RD_VALID(rdv),
    .DMA_RD_READY(rdr), .WR_VALID(wv), .WR_READY(wrr), .WR_DATA(wd),
    .WR_ADDR(wa), .WR_LANES(wl), .WR_DMA(wdma));
  task automatic end_sim;
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic [31:0] lmask(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  // strobe rise latches lanes and enable
  task automatic bus_addr(input logic [3:0] b);
    addr = 14'h0c1;
    be_n = b;
    aen = 1'b0;
    as_n = 1'b0;
    step(4);
    as_n = 1'b1;
    step(1);
  endtask
  task automatic io_write_all;
    logic [3:0] pat [7] = '{4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7};
    int n;
    for (int i = 0; i < 7; i++)
    begin
      bus_addr(pat[i]);
      chk(32'(ldec_n), 32'h0);
      din = 32'h0;
      wr_n = 1'b0;
      step(3);
      // only the trailing edge data may land
      din = 32'h9a7c5e31 + i;
      step(1);
      wr_n = 1'b1;
      n = 0;
      while (wv !== 1'b1 && n < 20)
      begin
        step(1);
        n++;
      end
      chk(wd, din & lmask(~pat[i]));
      chk(32'({wdma, wl}), {28'h0, ~pat[i]});
      chk(32'(wa), 32'h0c1);
      chk(32'(ca), 32'h0c1);
    end
  endtask
  task automatic io_refuse;
    bus_addr(4'h5);
    wr_n = 1'b0;
    step(3);
    wr_n = 1'b1;
    step(8);
    chk(32'({bad, wv}), 32'h2);
    // an address outside the window must not decode
    addr = 14'h0;
    step(5);
    chk(32'(ldec_n), 32'h1);
    // a matching address with the enable high must not decode
    addr = 14'h0c1;
    aen = 1'b1;
    as_n = 1'b0;
    step(5);
    chk(32'(ldec_n), 32'h1);
    as_n = 1'b1;
    step(3);
  endtask
  task automatic io_read;
    rdd = 32'h13579bdf;
    bus_addr(4'hc);
    rd_n = 1'b0;
    step(5);
    chk(32'(oe_n), 32'hc);
    chk(dout & 32'hffff, 32'h9bdf);
    rd_n = 1'b1;
    step(5);
    chk(32'(oe_n), 32'hf);
  endtask
  task automatic dma_write;
    int n = 0;
    dir = 1'b1;
    cyc_n = 1'b0;
    din = 32'h0d15ea5e;
    wrr = 1'b0;
    dsel_n = 1'b0;
    run = 1'b1;
    step(38);
    chk(32'({wv, wdma, wl}), 32'h3f);
    chk(wd, 32'h0d15ea5e);
    run = 1'b0;
    dsel_n = 1'b1;
    cyc_n = 1'b1;
    step(4);
    wrr = 1'b1;
    repeat (8)
    begin
      if (wv === 1'b1)
        n++;
      step(1);
    end
    chk(n, 2);
  endtask
  task automatic cnt_rdr(output int n);
    n = 0;
    repeat (34)
    begin
      if (rdr === 1'b1)
        n++;
      step(1);
    end
  endtask
  task automatic dma_read;
    int n;
    dir = 1'b0;
    rdv = 1'b1;
    drd = 32'h600dcafe;
    dsel_n = 1'b0;
    run = 1'b1;
    cnt_rdr(n);
    chk(n, 4);
    chk(dout, drd);
    chk(32'(oe_n), 32'h0);
    slow = 1'b1;
    step(10);
    cnt_rdr(n);
    chk(n, 0);
    run = 1'b0;
    dsel_n = 1'b1;
  endtask
  task automatic irq_check;
    irq = 1'b1;
    step(4);
    chk(32'(irq_o), 32'h1);
    irq = 1'b0;
    step(4);
    chk(32'(irq_o), 32'h0);
  endtask
  // hang guard, well past the expected length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    step(3);
    rst_n = 1'b1;
    step(3);
    io_write_all();
    io_refuse();
    io_read();
    dma_write();
    dma_read();
    irq_check();
    end_sim();
  end
endmodule
`default_nettype wire
